// *** verilog/wdt_pkg.sv ***
package wdt_pkg;

    // Register byte addresses on the bus.
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_CAUSE = 32'h0000_0004;

    // Field positions of the control and status register.
    localparam int unsigned BIT_FLAG = 7;
    localparam int unsigned BIT_IE = 6;
    localparam int unsigned BIT_SEL3 = 5;
    localparam int unsigned BIT_UNLOCK = 4;
    localparam int unsigned BIT_RE = 3;
    localparam int unsigned BIT_SEL2 = 2;
    localparam int unsigned BIT_SEL0 = 0;

    // Field position of the watchdog flag in the reset cause register.
    localparam int unsigned BIT_CAUSE = 3;

    // Reset values.
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Timing: the unlock window in system clocks, and the time-out table.
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam int unsigned CNT_W = 20;
    localparam logic [CNT_W-1:0] BASE_CYCLES = 20'h00800;
    localparam logic [3:0] SEL_MAX = 4'h9;

    // AHB transfer type bit that marks an active transfer.
    localparam int unsigned HTRANS_ACTIVE = 1;

    typedef enum logic [1:0]
    {
        BUS_ADDR = 2'b01,
        BUS_WDATA = 2'b10
    } wdt_bus_e;

    typedef struct packed
    {
        wdt_bus_e bus;
        logic wr_ctrl;
        logic wr_cause;
        logic [7:0] rdata;
        logic flag;
        logic ie;
        logic re;
        logic [3:0] sel;
        logic unlock;
        logic [2:0] ucnt;
        logic cause;
        logic [CNT_W-1:0] cnt;
        logic rst_pulse;
    } wdt_state_s;

    typedef struct packed
    {
        logic sync1;
        logic sync2;
        logic last;
    } wdt_edge_s;

endpackage

// *** verilog/wdt_osc_edge.sv ***
`timescale 1ns/1ps
module wdt_osc_edge
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Oscillator level and its rising edge.
    input wire logic osc_level,
    output logic osc_rise
);

    wdt_pkg::wdt_edge_s st_q;
    wdt_pkg::wdt_edge_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.sync1 = osc_level;
        st_d.sync2 = st_q.sync1;
        st_d.last = st_q.sync2;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // One pulse per oscillator period, taken after the two-flop synchroniser.
    assign osc_rise = st_q.sync2 & ~st_q.last;

endmodule

// *** verilog/wdt_timer.sv ***
`timescale 1ns/1ps
module wdt_timer
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Watchdog oscillator.
    input wire logic osc_level,
    // Core and fuse.
    input wire logic always_on_fuse,
    input wire logic core_irq_global_en,
    input wire logic irq_ack,
    input wire logic wdt_restart,
    // Interrupt and reset outputs.
    output logic irq_req,
    output logic sys_reset_pulse
);

    ////////////////////////////////////////////////////////////////////////////////////

    wdt_pkg::wdt_state_s st_q;
    wdt_pkg::wdt_state_s st_d;
    logic osc_rise;
    logic re_eff;
    logic ie_eff;
    logic running;
    logic expire;
    logic [wdt_pkg::CNT_W-1:0] lim;
    logic [7:0] ctrl_view;
    logic addr_take;
    logic [7:0] w;

    // Last count of the period for a select code; reserved codes act as the longest.
    function automatic logic [wdt_pkg::CNT_W-1:0] period_last(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > wdt_pkg::SEL_MAX) ? wdt_pkg::SEL_MAX : sel;
        return (wdt_pkg::BASE_CYCLES << s) - 20'h00001;
    endfunction

    // Builds the control register view from the stored flag, sel and unlock and the fuse-adjusted ie and re.
    function automatic logic [7:0] ctrl_pack(input logic flag, input logic ie,
                                             input logic [3:0] sel, input logic unl,
                                             input logic re);
        logic [7:0] v;
        v = 8'h00;
        v[wdt_pkg::BIT_FLAG] = flag;
        v[wdt_pkg::BIT_IE] = ie;
        v[wdt_pkg::BIT_SEL3] = sel[3];
        v[wdt_pkg::BIT_UNLOCK] = unl;
        v[wdt_pkg::BIT_RE] = re;
        v[wdt_pkg::BIT_SEL2:wdt_pkg::BIT_SEL0] = sel[2:0];
        return v;
    endfunction

    wdt_osc_edge u_osc_edge
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .osc_level(osc_level),
        .osc_rise(osc_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////////

    // The fuse forces reset mode; the cause flag already holds re set.
    assign re_eff = st_q.re | always_on_fuse;
    assign ie_eff = st_q.ie & ~always_on_fuse;
    assign running = re_eff | ie_eff;
    assign lim = period_last(st_q.sel);
    assign expire = running & osc_rise & ~wdt_restart & (st_q.cnt == lim);
    assign ctrl_view = ctrl_pack(st_q.flag, ie_eff, st_q.sel, st_q.unlock, re_eff);
    assign addr_take = hsel & hready & htrans[wdt_pkg::HTRANS_ACTIVE];
    assign w = hwdata[7:0];

    always_comb
    begin
        st_d = st_q;
        st_d.rst_pulse = 1'b0;

        // Bus address phase: read data is prepared, writes are held for the data phase.
        st_d.bus = wdt_pkg::BUS_ADDR;
        st_d.wr_ctrl = 1'b0;
        st_d.wr_cause = 1'b0;
        if (addr_take)
        begin
            st_d.rdata = wdt_pkg::RDATA_RESET;
            if (hwrite)
            begin
                st_d.bus = wdt_pkg::BUS_WDATA;
                st_d.wr_ctrl = (haddr == wdt_pkg::ADDR_CTRL);
                st_d.wr_cause = (haddr == wdt_pkg::ADDR_CAUSE);
            end
            else if (haddr == wdt_pkg::ADDR_CTRL)
            begin
                st_d.rdata = ctrl_view;
            end
            else if (haddr == wdt_pkg::ADDR_CAUSE)
            begin
                st_d.rdata[wdt_pkg::BIT_CAUSE] = st_q.cause;
            end
            else
            begin
                st_d.rdata = wdt_pkg::RDATA_RESET;
            end
        end

        // Unlock window countdown.
        if (st_q.unlock)
        begin
            st_d.ucnt = st_q.ucnt - 3'h1;
            if (st_q.ucnt == 3'h1)
            begin
                st_d.unlock = 1'b0;
            end
        end

        // Data phase writes.
        case (st_q.bus)
            wdt_pkg::BUS_WDATA:
            begin
                if (st_q.wr_ctrl)
                begin
                    if (w[wdt_pkg::BIT_FLAG])
                    begin
                        st_d.flag = 1'b0;
                    end
                    st_d.ie = w[wdt_pkg::BIT_IE];
                    if (w[wdt_pkg::BIT_UNLOCK] && w[wdt_pkg::BIT_RE])
                    begin
                        st_d.unlock = 1'b1;
                        st_d.ucnt = wdt_pkg::UNLOCK_CYCLES;
                        st_d.re = 1'b1;
                    end
                    else
                    begin
                        st_d.unlock = 1'b0;
                        if (w[wdt_pkg::BIT_RE])
                        begin
                            st_d.re = 1'b1;
                        end
                        else if (st_q.unlock && !st_q.cause)
                        begin
                            st_d.re = 1'b0;
                        end
                        if (st_q.unlock)
                        begin
                            st_d.sel = {w[wdt_pkg::BIT_SEL3],
                                        w[wdt_pkg::BIT_SEL2:wdt_pkg::BIT_SEL0]};
                        end
                    end
                end
                if (st_q.wr_cause && !w[wdt_pkg::BIT_CAUSE])
                begin
                    st_d.cause = 1'b0;
                end
            end
            wdt_pkg::BUS_ADDR:
            begin
                st_d.bus = st_d.bus;
            end
            default:
            begin
                st_d.bus = wdt_pkg::BUS_ADDR;
            end
        endcase

        // Vector execution clears the flag, and in combined mode the enable too.
        if (irq_ack)
        begin
            st_d.flag = 1'b0;
            if (re_eff)
            begin
                st_d.ie = 1'b0;
            end
        end

        // Counter on synchronised oscillator edges.
        if (!running || wdt_restart)
        begin
            st_d.cnt = '0;
        end
        else if (osc_rise)
        begin
            st_d.cnt = expire ? '0 : st_q.cnt + 20'h00001;
        end

        // Time-out action; a set here wins over any clear above.
        if (expire)
        begin
            if (re_eff && (!ie_eff || (st_q.flag && !irq_ack)))
            begin
                st_d.rst_pulse = 1'b1;
                st_d.cause = 1'b1;
                if (ie_eff)
                begin
                    st_d.flag = 1'b1;
                end
            end
            else if (ie_eff)
            begin
                st_d.flag = 1'b1;
            end
        end

        // The cause flag keeps reset enable set; the fuse blocks interrupt enable.
        if (st_d.cause)
        begin
            st_d.re = 1'b1;
        end
        if (always_on_fuse)
        begin
            st_d.ie = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q.bus <= wdt_pkg::BUS_ADDR;
            st_q.wr_ctrl <= 1'b0;
            st_q.wr_cause <= 1'b0;
            st_q.rdata <= wdt_pkg::RDATA_RESET;
            st_q.flag <= 1'b0;
            st_q.ie <= 1'b0;
            st_q.re <= 1'b0;
            st_q.sel <= wdt_pkg::SEL_RESET;
            st_q.unlock <= 1'b0;
            st_q.ucnt <= 3'h0;
            st_q.cause <= 1'b0;
            st_q.cnt <= '0;
            st_q.rst_pulse <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////

    assign hrdata = {24'h00_0000, st_q.rdata};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq_req = st_q.flag & ie_eff & core_irq_global_en;
    assign sys_reset_pulse = st_q.rst_pulse;

    ////////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_first_timeout;
        expire && re_eff && ie_eff && !st_q.flag;
    endsequence

    sequence s_second_timeout;
        expire && re_eff && ie_eff && st_q.flag && !irq_ack;
    endsequence

    a_flag_on_timeout: assert property (expire && ie_eff |=> st_q.flag)
        else $error("Time-out in interrupt mode did not set the flag.");

    a_ack_clears_flag: assert property (irq_ack && !expire |=> !st_q.flag)
        else $error("Vector execution did not clear the flag.");

    a_irq_gated: assert property (irq_req |-> core_irq_global_en && st_q.ie && st_q.flag)
        else $error("Interrupt requested without both enables.");

    a_combined_first: assert property (s_first_timeout |=> st_q.flag && !sys_reset_pulse)
        else $error("First combined time-out did not only set the flag.");

    a_combined_second: assert property (s_second_timeout |=> sys_reset_pulse)
        else $error("Unserviced combined time-out gave no reset.");

    a_unlock_window: assert property ($rose(st_q.unlock) |-> ##4 !st_q.unlock)
        else $error("Change-unlock stayed set past four clocks.");

    a_select_locked: assert property (!$past(st_q.unlock) |-> $stable(st_q.sel))
        else $error("Time-out select changed without unlock.");

    a_cause_forces_re: assert property ($past(st_q.cause) |-> st_q.re)
        else $error("Reset enable cleared while cause flag set.");

    a_fuse_locks_ie: assert property (always_on_fuse && $past(always_on_fuse) |-> !st_q.ie)
        else $error("Interrupt enable set while fuse programmed.");

    a_restart_zero: assert property (wdt_restart |=> st_q.cnt == '0)
        else $error("Restart did not clear the counter.");

    a_reset_one_cycle: assert property (sys_reset_pulse |=> !sys_reset_pulse && st_q.cause)
        else $error("Reset pulse longer than one clock or cause not set.");

    a_expire_at_limit: assert property (expire |-> st_q.cnt == lim && lim[10:0] == 11'h7FF)
        else $error("Time-out away from the selected period.");

    a_reset_mode_pulse: assert property (expire && re_eff && !ie_eff |=> sys_reset_pulse)
        else $error("Reset mode time-out gave no reset pulse.");

    a_irq_mode_quiet: assert property (expire && ie_eff && !re_eff |=> !sys_reset_pulse)
        else $error("Interrupt mode time-out gave a reset pulse.");

    a_stopped_count_zero: assert property (!running |=> st_q.cnt == '0)
        else $error("Counter moved while the watchdog was stopped.");

    a_re_clear_locked: assert property ($fell(st_q.re) |-> $past(st_q.unlock) && !$past(st_q.cause))
        else $error("Reset enable cleared without unlock or with cause set.");

    a_ack_leaves_combined: assert property (irq_ack && re_eff |=> !st_q.ie)
        else $error("Vector execution left interrupt enable set in combined mode.");

endmodule

// *** verification/wdt_core_model.sv ***
`timescale 1ns/1ps
// Core interrupt logic and reset controller facing the watchdog.
module wdt_core_model
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Watchdog requests.
    input wire logic irq_req,
    input wire logic sys_reset_pulse,
    // Bench control and observation.
    input wire logic ack_en,
    output logic irq_ack,
    output logic [7:0] reset_count
);
    logic [1:0] wait_q;

    // The vector runs three cycles after a request, once per request.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_q <= 2'h0;
            irq_ack <= 1'b0;
            reset_count <= 8'h00;
        end
        else
        begin
            irq_ack <= 1'b0;
            wait_q <= 2'h0;
            if (irq_req && ack_en && !irq_ack)
            begin
                wait_q <= wait_q + 2'h1;
                if (wait_q == 2'h2)
                begin
                    irq_ack <= 1'b1;
                end
            end
            if (sys_reset_pulse)
            begin
                reset_count <= reset_count + 8'h01;
            end
        end
    end
endmodule

// *** verification/tb_watchdog_timer_with_irq.sv ***
`timescale 1ns/1ps
module tb_watchdog_timer_with_irq;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq_req, sys_reset_pulse, irq_ack;
    logic osc_level = 1'b0;
    logic always_on_fuse = 1'b0;
    logic core_irq_global_en = 1'b0;
    logic wdt_restart = 1'b0;
    logic ack_en = 1'b0;
    logic [2:0] osc_div = 3'h0;
    logic [7:0] reset_count;
    logic [15:0] lfsr = 16'h9870;
    logic [31:0] rd, v;
    logic [3:0] sel;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;

    wdt_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_level(osc_level),
        .always_on_fuse(always_on_fuse), .core_irq_global_en(core_irq_global_en),
        .irq_ack(irq_ack), .wdt_restart(wdt_restart), .irq_req(irq_req),
        .sys_reset_pulse(sys_reset_pulse));

    wdt_core_model i_core (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
        .sys_reset_pulse(sys_reset_pulse), .ack_en(ack_en), .irq_ack(irq_ack),
        .reset_count(reset_count));

    assign hready = hreadyout;

    always #10 hclk = ~hclk;

    // Oscillator at one eighth of the bus clock, and the hang limit.
    always @(posedge hclk)
    begin
        osc_div <= osc_div + 3'h1;
        osc_level <= osc_div[2];
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Control word for a reset enable and a select code.
    function automatic logic [31:0] ctrl_val(input logic re, input logic [3:0] s);
        return {24'h0, 2'b00, s[3], 1'b0, re, s[2:0]};
    endfunction

    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic wait_irq();
        n = 0;
        while (irq_req !== 1'b1)
        begin
            @(posedge hclk);
            n = n + 1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("ctrl reset", wdt_pkg::ADDR_CTRL, 32'h0);
        rdc("cause reset", wdt_pkg::ADDR_CAUSE, 32'h0);
        chk("hresp okay", 32'h0, 32'(hresp));
        bus(1'b1, 32'h10, 32'hFF);
        rdc("unmapped read", 32'h10, 32'h0);
        rdc("unmapped write", wdt_pkg::ADDR_CTRL, 32'h0);
        // Interrupt mode, timed from a restart.
        core_irq_global_en <= 1'b1;
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h40);
        @(posedge hclk);
        wdt_restart <= 1'b1;
        @(posedge hclk);
        wdt_restart <= 1'b0;
        wait_irq();
        chk("timeout length", 32'h1, 32'(n >= 16370 && n <= 16410));
        rdc("flag set", wdt_pkg::ADDR_CTRL, 32'hC0);
        chk("no reset in irq mode", 32'h0, 32'(reset_count));
        core_irq_global_en <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("irq gated", 32'h0, 32'(irq_req));
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'hC0);
        rdc("flag cleared by one", wdt_pkg::ADDR_CTRL, 32'h40);
        // Combined mode with the vector executed.
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h48);
        core_irq_global_en <= 1'b1;
        ack_en <= 1'b1;
        wait_irq();
        repeat (8) @(posedge hclk);
        rdc("vector to reset mode", wdt_pkg::ADDR_CTRL, 32'h08);
        chk("first timeout no reset", 32'h0, 32'(reset_count));
        // Combined mode left unserviced.
        ack_en <= 1'b0;
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h48);
        wait_irq();
        n = 0;
        while (sys_reset_pulse !== 1'b1)
        begin
            @(posedge hclk);
            n = n + 1;
        end
        @(posedge hclk);
        chk("reset pulse width", 32'h0, 32'(sys_reset_pulse));
        chk("reset on second timeout", 32'h1, 32'(n >= 16370 && n <= 16410));
        chk("one reset", 32'h1, 32'(reset_count));
        rdc("cause set", wdt_pkg::ADDR_CAUSE, 32'h08);
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h80);
        rdc("enabled after reset", wdt_pkg::ADDR_CTRL, 32'h08);
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h00);
        rdc("re forced by cause", wdt_pkg::ADDR_CTRL, 32'h08);
        bus(1'b1, wdt_pkg::ADDR_CAUSE, 32'h00);
        rdc("cause cleared", wdt_pkg::ADDR_CAUSE, 32'h0);
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
        rdc("unlock set", wdt_pkg::ADDR_CTRL, 32'h18);
        repeat (6) @(posedge hclk);
        rdc("unlock expired", wdt_pkg::ADDR_CTRL, 32'h08);
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h21);
        rdc("locked change", wdt_pkg::ADDR_CTRL, 32'h08);
        for (int i = 0; i < 5; i++)
        begin
            lfsr = lfsr_next(lfsr);
            sel = (lfsr[3:0] > 4'h9) ? lfsr[3:0] - 4'h6 : lfsr[3:0];
            v = (i == 4) ? ctrl_val(1'b0, 4'h9) : ctrl_val(lfsr[4], sel);
            v = (i == 3) ? ctrl_val(1'b1, 4'hF) : v;
            wdt_restart <= 1'b1;
            bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
            wdt_restart <= 1'b0;
            bus(1'b1, wdt_pkg::ADDR_CTRL, v);
            rdc("unlocked change", wdt_pkg::ADDR_CTRL, v);
        end
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h18);
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h00);
        rdc("stopped", wdt_pkg::ADDR_CTRL, 32'h0);
        always_on_fuse <= 1'b1;
        bus(1'b1, wdt_pkg::ADDR_CTRL, 32'h40);
        rdc("fuse forces reset mode", wdt_pkg::ADDR_CTRL, 32'h08);
        always_on_fuse <= 1'b0;
        report_and_stop();
    end
endmodule
